// ### dv/tcc_channels_tb.sv
// Self-checking bench for the capture/compare channels
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; \
  $display("unexpected %s: expected %0h seen %0h", n, e, g); end end

module tcc_channels_tb
  import tcc_pkg::*;
;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  tcc_bus_req_t bus = '0;
  logic [7:0] rdata;
  logic cap_pin, pin1, pin2, cap_irq, cmp_irq;
  int fails = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [15:0] e, f;

  always #2.5 clk_i = ~clk_i;
  // Mirrors the timer: counter is FFFC + cyc/4 in the cycle numbered cyc
  always @(posedge clk_i) cyc <= srst_i ? 0 : cyc + 1;

  tcc_channels i_dut (.clk_i(clk_i), .srst_i(srst_i), .bus_i(bus), .rdata_o(rdata),
    .capture_pin_two_i(cap_pin), .compare_pin_one_o(pin1), .compare_pin_two_o(pin2),
    .capture_irq_o(cap_irq), .compare_irq_o(cmp_irq));
  tcc_pin_model i_pins (.clk_i(clk_i), .capture_pin_two_o(cap_pin));

  // =============================================================
  // Bus tasks
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i) bus <= '0;
  endtask : wr

  task automatic rc(input logic [7:0] a, input logic [7:0] x);
    @(posedge clk_i) bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i) bus <= '0;
    @(negedge clk_i) `CHK($sformatf("reg %h", a), x, rdata)
  endtask : rc

  task automatic rst();
    @(posedge clk_i) srst_i <= 1'b1;
    repeat (16) @(posedge clk_i);
    srst_i <= 1'b0;
  endtask : rst

  task automatic at(input int n);
    do @(negedge clk_i); while (cyc != n);
  endtask : at

  // Edge lands at the start of a counter period, so a sampler delay of
  // one cycle cannot move the captured count
  task automatic cap();
    do @(negedge clk_i); while (cyc % 4 != 3);
    e = 16'hFFFC + 16'((cyc + 1) / 4 + 1);
    i_pins.pulse();
  endtask : cap

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict

  initial begin
    #50us;
    fails++;
    give_verdict();
  end

  // =============================================================
  // Tests
  initial begin
    rst();
    wr(8'h16, 8'h00);
    wr(8'h17, 8'h04);
    wr(8'h1F, 8'h04);
    wr(8'h1E, 8'h00);
    // Compare values start undefined, so pins are forced to a known level
    wr(8'h12, 8'h58);
    wr(8'h12, 8'h43);
    rc(8'h1F, 8'h04);
    at(33);
    `CHK("pin1", 1'b0, pin1)
    at(34);
    `CHK("pin1", 1'b1, pin1)
    `CHK("pin2", 1'b0, pin2)
    `CHK("cmp_irq", 1'b1, cmp_irq)
    wr(8'h1F, 8'h08);
    wr(8'h12, 8'h42);
    wr(8'h17, 8'h0C);
    at(50);
    `CHK("pin2", 1'b1, pin2)
    at(65);
    `CHK("pin1", 1'b1, pin1)
    at(66);
    `CHK("pin1", 1'b0, pin1)
    rc(8'h13, 8'h48);
    wr(8'h12, 8'h02);
    rc(8'h12, 8'h02);
    `CHK("cmp_irq", 1'b0, cmp_irq)
    rc(8'h17, 8'h0C);
    rc(8'h13, 8'h08);
    rc(8'h1F, 8'h08);
    rc(8'h13, 8'h00);
    wr(8'h12, 8'h59);
    rc(8'h12, 8'h41);
    `CHK("pin1", 1'b1, pin1)
    `CHK("pin2", 1'b0, pin2)
    rc(8'h13, 8'h00);
    `CHK("cmp_irq", 1'b0, cmp_irq)
    rc(8'h00, 8'h00);
    wr(8'h12, 8'h80);
    cap();
    rc(8'h13, 8'h10);
    `CHK("cap_irq", 1'b1, cap_irq)
    rc(8'h1C, e[15:8]);
    rc(8'h1D, e[7:0]);
    rc(8'h13, 8'h00);
    `CHK("cap_irq", 1'b0, cap_irq)
    cap();
    cap();
    rc(8'h1C, e[15:8]);
    f = e;
    // High byte read above holds this capture back
    cap();
    rc(8'h1D, f[7:0]);
    cap();
    wr(8'h1C, 8'hFF);
    rc(8'h1C, e[15:8]);
    rc(8'h1D, e[7:0]);
    rst();
    rc(8'h1C, e[15:8]);
    rc(8'h1D, e[7:0]);
    // Recommended initialisation order: high byte, status read, low byte
    wr(8'h16, 8'h00);
    rc(8'h13, 8'h00);
    wr(8'h17, 8'h0C);
    rc(8'h16, 8'h00);
    rc(8'h17, 8'h0C);
    rc(8'h13, 8'h00);
    `CHK("pin1", 1'b0, pin1)
    give_verdict();
  end
endmodule : tcc_channels_tb

// ### dv/tcc_pin_model.sv
// Far-side model of the capture input pin
`timescale 1ns/1ps

module tcc_pin_model (
  input wire logic clk_i,
  output logic capture_pin_two_o
);
  // =============================================================
  // Capture pin
  // Idles high so that only a commanded pulse makes a falling edge
  initial capture_pin_two_o = 1'b1;

  // Low for three cycles so a two-stage input sampler still sees the edge
  task automatic pulse();
    @(posedge clk_i) capture_pin_two_o <= 1'b0;
    repeat (3) @(posedge clk_i);
    capture_pin_two_o <= 1'b1;
  endtask : pulse
endmodule : tcc_pin_model

// ### hw/tcc_channels.sv
// Second input capture channel, two output compare channels and the timer counter
`timescale 1ns/1ps
`include "tcc_defs.svh"

module tcc_channels
  import tcc_pkg::*;
#(
  parameter int unsigned PRESCALE = `TCC_PRESCALE
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire tcc_bus_req_t bus_i,
  output logic [7:0] rdata_o,
  input wire logic capture_pin_two_i,
  output logic compare_pin_one_o,
  output logic compare_pin_two_o,
  output logic capture_irq_o,
  output logic compare_irq_o
);

  // =============================================================
  // Elaboration checks
  if (PRESCALE < 2 || PRESCALE > 4) begin : g_bad_prescale
    $error("PRESCALE must lie between 2 and 4");
  end

  localparam logic [1:0] LAST_PHASE = 2'(PRESCALE - 1);
  localparam logic [1:0][7:0] CMP_HI_OFF = {`TCC_OFF_CMP2_HI, `TCC_OFF_CMP1_HI};
  localparam logic [1:0][7:0] CMP_LO_OFF = {`TCC_OFF_CMP2_LO, `TCC_OFF_CMP1_LO};

  function automatic logic hit(input tcc_bus_req_t b, input logic [7:0] off);
    hit = (b.addr == off);
  endfunction : hit

  tcc_state_t state_q;
  tcc_state_t state_d;

  logic cap_fall;
  logic cap_hi_rd;
  logic cap_lo_rd;
  logic stat_rd;
  logic ctrl_wr;
  logic [1:0] match;
  logic [1:0] force_hit;
  logic [1:0] lo_access;
  logic [1:0] hi_wr;
  logic [1:0] lo_wr;

  // =============================================================
  // Next-state logic
  always_comb begin
    state_d = state_q;
    cap_fall = state_q.cap_prev & ~capture_pin_two_i;
    cap_hi_rd = bus_i.rd & hit(bus_i, `TCC_OFF_CAP2_HI);
    cap_lo_rd = bus_i.rd & hit(bus_i, `TCC_OFF_CAP2_LO);
    stat_rd = bus_i.rd & hit(bus_i, `TCC_OFF_STAT);
    ctrl_wr = bus_i.wr & hit(bus_i, `TCC_OFF_CTRL);
    match = 2'h0;
    force_hit = 2'h0;
    lo_access = 2'h0;
    hi_wr = 2'h0;
    lo_wr = 2'h0;

    // Timer phase and counter: one count per prescale period
    state_d.cap_prev = capture_pin_two_i;
    if (state_q.phase == LAST_PHASE) begin
      state_d.phase = 2'h0;
      state_d.count = state_q.count + 16'h0001; // RULE_05
    end else begin
      state_d.phase = state_q.phase + 2'h1;
    end

    // Control register: levels and enables stored, force bits act once
    if (ctrl_wr) begin
      state_d.cap_irq_en = bus_i.wdata[`TCC_CTRL_CAP_IE];
      state_d.cmp_irq_en = bus_i.wdata[`TCC_CTRL_CMP_IE];
      state_d.match_level[0] = bus_i.wdata[`TCC_CTRL_LVL1];
      state_d.match_level[1] = bus_i.wdata[`TCC_CTRL_LVL2];
      force_hit[0] = bus_i.wdata[`TCC_CTRL_FORCE1]; // RULE_17
      force_hit[1] = bus_i.wdata[`TCC_CTRL_FORCE2]; // RULE_17
    end

    // Status read arms the clear of every flag that is set now
    if (stat_rd) begin
      state_d.cap_arm = state_q.cap_flag;
      state_d.cmp_arm = state_q.cmp_flag;
    end

    // Capture channel two
    if (cap_hi_rd) begin
      state_d.cap_inhibit = 1'b1; // RULE_07
    end
    if (cap_lo_rd) begin
      state_d.cap_inhibit = 1'b0; // RULE_07
      if (state_q.cap_arm) begin
        state_d.cap_flag = 1'b0; // RULE_21
        state_d.cap_arm = 1'b0;
      end
    end
    if (cap_fall) begin
      // Transfer on every edge unless software is between the two byte reads
      if (!state_q.cap_inhibit) begin
        state_d.cap_val = state_q.count + 16'h0001; // RULE_01 RULE_04 RULE_06
      end
      state_d.cap_flag = 1'b1; // RULE_02
    end

    // Compare channels
    for (int i = 0; i < 2; i++) begin
      hi_wr[i] = bus_i.wr & hit(bus_i, CMP_HI_OFF[i]);
      lo_wr[i] = bus_i.wr & hit(bus_i, CMP_LO_OFF[i]);
      lo_access[i] = (bus_i.wr | bus_i.rd) & hit(bus_i, CMP_LO_OFF[i]);
      if (hi_wr[i]) begin
        state_d.cmp_val[i][15:8] = bus_i.wdata; // RULE_13 RULE_15
        state_d.cmp_inhibit[i] = 1'b1; // RULE_12
      end
      if (lo_wr[i]) begin
        state_d.cmp_val[i][7:0] = bus_i.wdata; // RULE_13 RULE_15
        state_d.cmp_inhibit[i] = 1'b0; // RULE_12
      end
      if (lo_access[i] && state_q.cmp_arm[i]) begin
        state_d.cmp_flag[i] = 1'b0; // RULE_22
        state_d.cmp_arm[i] = 1'b0;
      end
      // Compare once per period, only in the fixed compare phase
      match[i] = (state_q.phase == `TCC_CMP_PHASE) && !state_q.cmp_inhibit[i]
                 && (state_q.cmp_val[i] == state_q.count); // RULE_23 RULE_24
      if (match[i]) begin
        state_d.cmp_flag[i] = 1'b1; // RULE_09 RULE_10
        state_d.pin[i] = state_q.match_level[i]; // RULE_14 RULE_20
      end
      // Force uses the level written in the same cycle, and touches no flag
      if (force_hit[i]) begin
        state_d.pin[i] = state_d.match_level[i]; // RULE_18 RULE_19
      end
    end

    state_d.cap_irq = state_d.cap_flag & state_d.cap_irq_en; // RULE_02
    state_d.cmp_irq = (|state_d.cmp_flag) & state_d.cmp_irq_en; // RULE_11

    // Read data, valid the cycle after the strobe only
    state_d.rdata = 8'h00;
    if (bus_i.rd) begin
      unique case (bus_i.addr)
        `TCC_OFF_CTRL: begin
          state_d.rdata[`TCC_CTRL_CAP_IE] = state_q.cap_irq_en;
          state_d.rdata[`TCC_CTRL_CMP_IE] = state_q.cmp_irq_en;
          state_d.rdata[`TCC_CTRL_LVL1] = state_q.match_level[0];
          state_d.rdata[`TCC_CTRL_LVL2] = state_q.match_level[1];
        end
        `TCC_OFF_STAT: begin
          state_d.rdata[`TCC_STAT_CMP1] = state_q.cmp_flag[0];
          state_d.rdata[`TCC_STAT_CAP2] = state_q.cap_flag;
          state_d.rdata[`TCC_STAT_CMP2] = state_q.cmp_flag[1];
        end
        `TCC_OFF_CMP1_HI: state_d.rdata = state_q.cmp_val[0][15:8];
        `TCC_OFF_CMP1_LO: state_d.rdata = state_q.cmp_val[0][7:0];
        `TCC_OFF_CNT_HI: state_d.rdata = state_q.count[15:8];
        `TCC_OFF_CNT_LO: state_d.rdata = state_q.count[7:0];
        `TCC_OFF_CAP2_HI: state_d.rdata = state_q.cap_val[15:8]; // RULE_03
        `TCC_OFF_CAP2_LO: state_d.rdata = state_q.cap_val[7:0]; // RULE_03
        `TCC_OFF_CMP2_HI: state_d.rdata = state_q.cmp_val[1][15:8];
        `TCC_OFF_CMP2_LO: state_d.rdata = state_q.cmp_val[1][7:0];
        default: state_d.rdata = 8'h00;
      endcase
    end
  end

  // =============================================================
  // State register
  // Compare and capture values deliberately have no reset: software may
  // use them as storage across a reset.
  always_ff @(posedge clk_i) begin
    state_q <= state_d;
    if (srst_i) begin
      state_q.count <= `TCC_COUNT_RST;
      state_q.phase <= 2'h0;
      state_q.cmp_inhibit <= 2'h0;
      state_q.cmp_flag <= 2'h0;
      state_q.cmp_arm <= 2'h0;
      state_q.match_level <= 2'h0;
      state_q.pin <= 2'h0;
      state_q.cap_inhibit <= 1'b0; // RULE_08
      state_q.cap_flag <= 1'b0;
      state_q.cap_arm <= 1'b0;
      state_q.cap_prev <= 1'b1;
      state_q.cap_irq_en <= 1'b0;
      state_q.cmp_irq_en <= 1'b0;
      state_q.cap_irq <= 1'b0;
      state_q.cmp_irq <= 1'b0;
      state_q.rdata <= 8'h00;
    end
  end

  assign rdata_o = state_q.rdata;
  assign compare_pin_one_o = state_q.pin[0];
  assign compare_pin_two_o = state_q.pin[1];
  assign capture_irq_o = state_q.cap_irq;
  assign compare_irq_o = state_q.cmp_irq;

  // =============================================================
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  a_count_step: assert property ( // RULE_05
    (state_q.phase == LAST_PHASE) |=> (state_q.count == $past(state_q.count) + 16'h0001)
  ) else $error("counter did not advance at end of period");

  a_count_hold: assert property ( // RULE_05
    (state_q.phase != LAST_PHASE) |=> $stable(state_q.count)
  ) else $error("counter moved inside a period");

  a_cap_latch: assert property ( // RULE_04
    (cap_fall && !state_q.cap_inhibit && !$past(srst_i))
      |=> (state_q.cap_val == $past(state_q.count) + 16'h0001) && state_q.cap_flag
  ) else $error("capture value or flag wrong after falling edge");

  a_cap_block: assert property ( // RULE_07
    (cap_hi_rd && !cap_lo_rd) ##1 (!cap_lo_rd)[*3] |=> $stable(state_q.cap_val)
  ) else $error("capture transferred while high byte read pending");

  a_cap_readback: assert property ( // RULE_03
    cap_lo_rd ##1 cap_hi_rd |=> (rdata_o == $past(state_q.cap_val[15:8]))
                                && ($past(rdata_o, 1) == $past(state_q.cap_val[7:0], 2))
  ) else $error("capture bytes read back wrong");

  a_cmp1_match: assert property ( // RULE_09
    (match[0] && !force_hit[0]) |=> state_q.cmp_flag[0]
                                    && (compare_pin_one_o == $past(state_q.match_level[0]))
  ) else $error("compare one match not applied");

  a_cmp2_match: assert property ( // RULE_10
    (match[1] && !force_hit[1]) |=> state_q.cmp_flag[1]
                                    && (compare_pin_two_o == $past(state_q.match_level[1]))
  ) else $error("compare two match not applied");

  a_cmp_suspend: assert property ( // RULE_12
    hi_wr[0] ##1 (!lo_wr[0])[*4] |-> !match[0] && state_q.cmp_inhibit[0]
  ) else $error("compare one ran while suspended");

  a_force_pin: assert property ( // RULE_19
    (ctrl_wr && bus_i.wdata[`TCC_CTRL_FORCE1] && !match[0] && !lo_access[0])
      |=> (compare_pin_one_o == $past(bus_i.wdata[`TCC_CTRL_LVL1]))
          && $stable(state_q.cmp_flag[0])
  ) else $error("forced compare wrong");

  a_cmp_irq: assert property ( // RULE_11
    compare_irq_o == ((|state_q.cmp_flag) && state_q.cmp_irq_en)
  ) else $error("compare interrupt not gated by enable");

  a_ctrl_force_rd: assert property ( // RULE_17
    (bus_i.rd && hit(bus_i, `TCC_OFF_CTRL)) |=> (rdata_o[4:3] == 2'h0)
  ) else $error("force bits did not read zero");

  // =============================================================
  // Timer phase
  a_phase_wrap: assert property ( // RULE_05
    (state_q.phase == LAST_PHASE) |=> (state_q.phase == 2'h0)
  ) else $error("phase did not wrap at end of period");

  a_phase_step: assert property ( // RULE_05
    (state_q.phase != LAST_PHASE) |=> (state_q.phase == $past(state_q.phase) + 2'h1)
  ) else $error("phase did not step");

  a_count_read: assert property ( // RULE_05
    (bus_i.rd && hit(bus_i, `TCC_OFF_CNT_LO)) |=> (rdata_o == $past(state_q.count[7:0]))
  ) else $error("counter low byte read back wrong");

  // =============================================================
  // Capture channel two
  // Value checks avoid cycles before the first capture, when the value is unknown
  a_cap_hold_inh: assert property ( // RULE_07
    (cap_fall && state_q.cap_inhibit) |=> $stable(state_q.cap_val)
  ) else $error("capture transferred while inhibited");

  a_cap_flag_set: assert property ( // RULE_06
    cap_fall |=> state_q.cap_flag
  ) else $error("capture flag not set by falling edge");

  a_cap_inh_set: assert property ( // RULE_07
    cap_hi_rd |=> state_q.cap_inhibit
  ) else $error("high byte read did not inhibit capture");

  a_cap_lo_free: assert property ( // RULE_07
    cap_lo_rd |=> !state_q.cap_inhibit
  ) else $error("low byte read left capture inhibited");

  a_cap_arm_set: assert property ( // RULE_21
    (stat_rd && state_q.cap_flag) |=> state_q.cap_arm
  ) else $error("status read did not arm capture flag clear");

  a_cap_clear: assert property ( // RULE_21
    (cap_lo_rd && state_q.cap_arm && !cap_fall) |=> !state_q.cap_flag
  ) else $error("capture flag not cleared");

  a_cap_no_arm: assert property ( // RULE_21
    (cap_lo_rd && !state_q.cap_arm && state_q.cap_flag) |=> state_q.cap_flag
  ) else $error("capture flag cleared without status read");

  a_cap_kept: assert property ( // RULE_21
    (state_q.cap_flag && !cap_lo_rd) |=> state_q.cap_flag
  ) else $error("capture flag lost without low byte read");

  a_cap_irq: assert property ( // RULE_02
    capture_irq_o == (state_q.cap_flag && state_q.cap_irq_en)
  ) else $error("capture interrupt not gated by enable");

  a_stat_cap_rd: assert property ( // RULE_02
    stat_rd |=> (rdata_o[`TCC_STAT_CAP2] == $past(state_q.cap_flag))
  ) else $error("status shows wrong capture flag");

  // =============================================================
  // Compare channels
  a_cmp1_hi_wr: assert property ( // RULE_13
    hi_wr[0] |=> (state_q.cmp_val[0][15:8] == $past(bus_i.wdata))
  ) else $error("compare one high byte not written");

  a_cmp1_lo_wr: assert property ( // RULE_13
    lo_wr[0] |=> (state_q.cmp_val[0][7:0] == $past(bus_i.wdata))
  ) else $error("compare one low byte not written");

  a_cmp2_hi_wr: assert property ( // RULE_13
    hi_wr[1] |=> (state_q.cmp_val[1][15:8] == $past(bus_i.wdata))
  ) else $error("compare two high byte not written");

  a_cmp2_lo_wr: assert property ( // RULE_13
    lo_wr[1] |=> (state_q.cmp_val[1][7:0] == $past(bus_i.wdata))
  ) else $error("compare two low byte not written");

  a_cmp_resume: assert property ( // RULE_12
    lo_wr[0] |=> !state_q.cmp_inhibit[0]
  ) else $error("compare one still suspended after low write");

  a_cmp2_suspend: assert property ( // RULE_12
    hi_wr[1] |=> state_q.cmp_inhibit[1]
  ) else $error("compare two not suspended by high write");

  a_cmp1_rd: assert property ( // RULE_15
    (bus_i.rd && hit(bus_i, `TCC_OFF_CMP1_LO)) |=> (rdata_o == $past(state_q.cmp_val[0][7:0]))
  ) else $error("compare one low byte read back wrong");

  a_cmp2_rd: assert property ( // RULE_15
    (bus_i.rd && hit(bus_i, `TCC_OFF_CMP2_LO)) |=> (rdata_o == $past(state_q.cmp_val[1][7:0]))
  ) else $error("compare two low byte read back wrong");

  a_cmp1_clear: assert property ( // RULE_22
    (lo_access[0] && state_q.cmp_arm[0] && !match[0]) |=> !state_q.cmp_flag[0]
  ) else $error("compare one flag not cleared");

  a_cmp2_clear: assert property ( // RULE_22
    (lo_access[1] && state_q.cmp_arm[1] && !match[1]) |=> !state_q.cmp_flag[1]
  ) else $error("compare two flag not cleared");

  a_flag1_kept: assert property ( // RULE_22
    (state_q.cmp_flag[0] && !lo_access[0]) |=> state_q.cmp_flag[0]
  ) else $error("compare one flag lost without low byte access");

  a_flag2_kept: assert property ( // RULE_22
    (state_q.cmp_flag[1] && !lo_access[1]) |=> state_q.cmp_flag[1]
  ) else $error("compare two flag lost without low byte access");

  // =============================================================
  // Pins and force
  a_pin1_hold: assert property ( // RULE_19
    (!match[0] && !force_hit[0]) |=> $stable(compare_pin_one_o)
  ) else $error("compare pin one moved without match or force");

  a_pin2_hold: assert property ( // RULE_19
    (!match[1] && !force_hit[1]) |=> $stable(compare_pin_two_o)
  ) else $error("compare pin two moved without match or force");

  a_force2_pin: assert property ( // RULE_18
    (ctrl_wr && bus_i.wdata[`TCC_CTRL_FORCE2])
      |=> (compare_pin_two_o == $past(bus_i.wdata[`TCC_CTRL_LVL2]))
  ) else $error("forced compare two wrong level");

  a_force2_flag: assert property ( // RULE_19
    (ctrl_wr && bus_i.wdata[`TCC_CTRL_FORCE2] && !match[1]) |=> $stable(state_q.cmp_flag[1])
  ) else $error("forced compare two touched its flag");

  a_rdata_idle: assert property ( // RULE_03
    !bus_i.rd |=> (rdata_o == 8'h00)
  ) else $error("read data not idle after no read");

endmodule : tcc_channels

// ### hw/tcc_defs.svh
// Register offsets, field positions, reset values and timing counts of the capture/compare block
// Summary of operation
// RULE_01 Falling edge on capture pin two latches the free-running counter into capture two.
// RULE_02 Each capture two sets its flag; interrupt raised when capture enable set.
// RULE_03 Capture two high byte reads upper eight bits, low byte lower eight.
// RULE_04 Captured value is one more than counter before the transition.
// RULE_05 Free-running counter advances once every four bus clock cycles.
// RULE_06 Capture transfer happens on every falling edge, whatever the flag state.
// RULE_07 Reading capture high byte blocks transfers until low byte is read.
// RULE_08 Reset leaves capture two contents unchanged.
// RULE_09 Compare one match sets flag one and drives level one to pin one.
// RULE_10 Compare two match sets flag two and drives level two to pin two.
// RULE_11 One compare interrupt enable gates interrupts from both compare channels.
// RULE_12 Writing compare high byte suspends that channel until its low byte is written.
// RULE_13 Each compare byte is writable without changing the other byte.
// RULE_14 On match the level reaches the pin whether or not the flag is set.
// RULE_15 Compare registers read/write, untouched by hardware and reset.
// RULE_16 Software writes high byte, reads status, then writes low byte when initialising.
// RULE_17 Control bits 3 and 4 force levels to pins; they always read zero.
// RULE_18 One control write changing levels and forcing drives the new levels.
// RULE_19 A forced compare changes only the pin, no flag, no interrupt.
// RULE_20 Level bit one drives pin high at match, zero drives it low.
// RULE_21 Capture flag two clears on status read then capture low byte read.
// RULE_22 Compare flag clears on status read then that channel's low byte access.
// RULE_23 Comparison evaluated once per four-cycle period in a fixed timer phase.
// RULE_24 Match needs all sixteen bits equal, once per counter period.
`ifndef TCC_DEFS_SVH
`define TCC_DEFS_SVH

// =============================================================
// Register offsets
`define TCC_OFF_CTRL 8'h12
`define TCC_OFF_STAT 8'h13
`define TCC_OFF_CMP1_HI 8'h16
`define TCC_OFF_CMP1_LO 8'h17
`define TCC_OFF_CNT_HI 8'h18
`define TCC_OFF_CNT_LO 8'h19
`define TCC_OFF_CAP2_HI 8'h1C
`define TCC_OFF_CAP2_LO 8'h1D
`define TCC_OFF_CMP2_HI 8'h1E
`define TCC_OFF_CMP2_LO 8'h1F

// =============================================================
// Control register fields
`define TCC_CTRL_CAP_IE 7
`define TCC_CTRL_CMP_IE 6
`define TCC_CTRL_FORCE2 4
`define TCC_CTRL_FORCE1 3
`define TCC_CTRL_LVL2 1
`define TCC_CTRL_LVL1 0

// =============================================================
// Status register fields
`define TCC_STAT_CMP1 6
`define TCC_STAT_CAP2 4
`define TCC_STAT_CMP2 3

// =============================================================
// Reset values and timing
`define TCC_COUNT_RST 16'hFFFC
`define TCC_PRESCALE 4
`define TCC_CMP_PHASE 2'h1

`endif

// ### hw/tcc_pkg.sv
// Types shared by the timer capture/compare block
package tcc_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tcc_bus_req_t;

  typedef struct packed {
    logic [15:0] count;
    logic [1:0] phase;
    logic [1:0][15:0] cmp_val;
    logic [1:0] cmp_inhibit;
    logic [1:0] cmp_flag;
    logic [1:0] cmp_arm;
    logic [1:0] match_level;
    logic [1:0] pin;
    logic [15:0] cap_val;
    logic cap_inhibit;
    logic cap_flag;
    logic cap_arm;
    logic cap_prev;
    logic cap_irq_en;
    logic cmp_irq_en;
    logic cap_irq;
    logic cmp_irq;
    logic [7:0] rdata;
  } tcc_state_t;

endpackage : tcc_pkg
